// file: rtl/agds_params.svh
// Constants of the adaptive gate drive sequencer
// Assumes inclusion by bare name from the package and modules
`ifndef AGDS_PARAMS_SVH
`define AGDS_PARAMS_SVH
`define AGDS_CODE_W 6
`define AGDS_TIME_W 8
`define AGDS_CODE_MIN 6'h00
`define AGDS_CODE_MAX 6'h3F
`define AGDS_AGC_ADAPT_BIT 1
`define AGDS_CLK_MHZ 20
`endif

// file: rtl/agds_pkg.sv
// Types of the adaptive gate drive sequencer
// Assumes agds_params.svh on the include path
`include "agds_params.svh"
package agds_pkg;
    typedef logic [`AGDS_CODE_W-1:0] agds_code_t;
    typedef logic [`AGDS_TIME_W-1:0] agds_time_t;
    typedef enum logic [7:0] {
        AGDS_IDLE_ON = 8'h01,
        AGDS_CCP_ON = 8'h02,
        AGDS_PRECHG = 8'h04,
        AGDS_CHG = 8'h08,
        AGDS_POSTCHG = 8'h10,
        AGDS_SYM = 8'h20,
        AGDS_PREDIS = 8'h40,
        AGDS_DIS = 8'h80
    } agds_state_e;
    typedef struct packed {
        logic on;
        logic source;
        agds_code_t code;
    } agds_gate_s;
    typedef struct packed {
        agds_code_t precharge_initial_current;
        agds_code_t predischarge_initial_current;
        agds_code_t charge_current;
        agds_code_t discharge_current;
        agds_code_t freewheel_gate_current;
        agds_code_t max_drive_current;
        agds_time_t freewheel_crossconduction_time;
        agds_time_t active_crossconduction_time;
        agds_time_t precharge_duration;
        agds_time_t predischarge_duration;
        agds_time_t overvoltage_filter_time;
        agds_time_t turn_on_target;
        agds_time_t turn_off_target;
    } agds_cfg_s;
endpackage

// file: rtl/agds_adapt.sv
// Adaptive current code for one phase (pre-charge or pre-discharge)
// Assumes one measurement pulse per PWM cycle
`timescale 1ns/10ps
`include "agds_params.svh"
module agds_adapt #(
    parameter int CODE_W = `AGDS_CODE_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Control
    input wire logic init_load,
    input wire logic [CODE_W-1:0] init_code,
    input wire logic [CODE_W-1:0] max_code,
    input wire logic adapt_on,
    input wire logic filter_on,
    input wire logic step_two,
    // Measurement
    input wire logic meas_done,
    input wire logic too_long,
    input wire logic too_short,
    // Result
    output logic [CODE_W-1:0] code
);
    logic [CODE_W-1:0] code_q;
    logic [CODE_W-1:0] code_d;
    logic prev_long_q;
    logic prev_short_q;
    logic [CODE_W:0] up_sum;
    logic [CODE_W-1:0] up_val;
    logic [CODE_W-1:0] dn_val;
    logic [CODE_W-1:0] init_min;
    logic [CODE_W-1:0] step;
    logic do_up;
    logic do_dn;
    assign step = step_two ? CODE_W'(2) : CODE_W'(1);
    assign init_min = (init_code < max_code) ? init_code : max_code;
    assign do_up = adapt_on & meas_done & too_long & (~filter_on | prev_long_q);
    assign do_dn = adapt_on & meas_done & too_short & (~filter_on | prev_short_q);
    assign up_sum = {1'b0, code_q} + {1'b0, step};
    assign up_val = (up_sum > {1'b0, max_code}) ? max_code : up_sum[CODE_W-1:0];
    assign dn_val = (code_q < step) ? CODE_W'(0) : code_q - step;
    assign code_d = init_load ? init_min : do_up ? up_val : do_dn ? dn_val :
                    (code_q > max_code) ? max_code : code_q;
    assign code = code_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            code_q <= '0;
            prev_long_q <= 1'b0;
            prev_short_q <= 1'b0;
        end else if (clk_en) begin
            code_q <= code_d;
            if (init_load) begin
                prev_long_q <= 1'b0;
                prev_short_q <= 1'b0;
            end else if (meas_done) begin
                prev_long_q <= too_long;
                prev_short_q <= too_short;
            end
        end
    end
    chk_code_clamp: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && !init_load && code_q <= max_code |=> code_q <= $past(max_code))
        else $error("adapt code above max");
    chk_filter_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && filter_on && meas_done && !init_load && !prev_long_q && !prev_short_q
        && code_q <= max_code |=> code_q == $past(code_q))
        else $error("filtered code moved on first sample");
    chk_init_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && init_load |=> code_q == $past(init_min))
        else $error("init load not minimum");
    chk_step_up: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && do_up && !init_load && up_sum <= {1'b0, max_code}
        |=> code_q == $past(code_q) + $past(step))
        else $error("wrong step size");
endmodule

// file: rtl/agds_seq.sv
// Adaptive gate drive sequencer for one half-bridge
// Assumes synchronous pwm_input and comparator inputs, config held stable
//
// Summary of operation
// - Rising edge: protection time, low gate discharged.
// - Then pre-charge with adaptive code.
// - Charge current, measure delay, end at threshold.
// - Post-charge ramps code each clock to max.
// - Adaptive code clamped between lowest and max.
// - Enable loads min of initial and max.
// - Unfiltered: long delay raises, short lowers.
// - Step one or two per setting.
// - Filter needs two agreeing cycles.
// - Falling edge delayed by protection time.
// - Then pre-discharge with adaptive code.
// - Discharge current, measure, end at active protection.
// - Low gate off, then charged until filter end.
// - Pre-discharge adapted likewise from turn-off delay.
// - Adaptation only with select bit one set.
// - Passive freewheel keeps complementary gate off.
// - Passive freewheel skips freewheel protection times.
// - Low-side mapping swaps gates and thresholds.
// - Measured delays are readable outputs.
// - Currents are six-bit step codes.
`timescale 1ns/10ps
`include "agds_params.svh"
module agds_seq #(
    parameter int CODE_W = `AGDS_CODE_W,
    parameter int TIME_W = `AGDS_TIME_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // PWM and mode
    input wire logic pwm_input,
    input wire logic bridge_pwm_enable,
    input wire logic pwm_on_low_side,
    input wire logic active_freewheel_enable,
    input wire logic [1:0] adaptive_gate_control_select,
    input wire logic adaptation_filter_enable,
    input wire logic adaptation_step_size,
    input wire agds_pkg::agds_cfg_s cfg,
    // Switch node comparators
    input wire logic switch_node_high,
    input wire logic switch_node_low,
    // Gate drives
    output agds_pkg::agds_gate_s high_gate,
    output agds_pkg::agds_gate_s low_gate,
    // Status
    output agds_pkg::agds_state_e phase,
    output agds_pkg::agds_code_t precharge_current,
    output agds_pkg::agds_code_t predischarge_current,
    output agds_pkg::agds_time_t turn_on_delay,
    output agds_pkg::agds_time_t turn_off_delay
);
    agds_pkg::agds_state_e st_q;
    agds_pkg::agds_state_e st_d;
    agds_pkg::agds_time_t cnt_q;
    agds_pkg::agds_time_t cnt_d;
    agds_pkg::agds_time_t meas_q;
    agds_pkg::agds_time_t ccp_q;
    agds_pkg::agds_time_t fv_q;
    agds_pkg::agds_time_t ton_q;
    agds_pkg::agds_time_t toff_q;
    agds_pkg::agds_code_t ramp_q;
    agds_pkg::agds_gate_s act_q;
    agds_pkg::agds_gate_s fw_q;
    agds_pkg::agds_gate_s act_d;
    agds_pkg::agds_gate_s fw_d;
    logic pwm_q;
    logic en_q;
    logic fwchg_q;
    logic rise;
    logic fall;
    logic en_rise;
    logic cnt_end;
    logic ccp_end;
    logic fv_end;
    logic sn_reached;
    logic sn_released;
    logic adapt_on;
    logic on_done;
    logic off_done;
    agds_pkg::agds_time_t fw_ccp;
    agds_pkg::agds_time_t cnt_m1;
    agds_pkg::agds_time_t meas_p1;
    agds_pkg::agds_code_t pre_code;
    agds_pkg::agds_code_t pdis_code;
    agds_pkg::agds_code_t ramp_up;
    assign rise = pwm_input & ~pwm_q;
    assign fall = ~pwm_input & pwm_q;
    assign en_rise = bridge_pwm_enable & ~en_q;
    assign adapt_on = adaptive_gate_control_select[`AGDS_AGC_ADAPT_BIT];
    assign fw_ccp = active_freewheel_enable ? cfg.freewheel_crossconduction_time : '0;
    assign cnt_m1 = cnt_q - TIME_W'(1);
    assign cnt_end = (cnt_q <= TIME_W'(1));
    assign ccp_end = (ccp_q <= TIME_W'(1));
    assign fv_end = (fv_q <= TIME_W'(1));
    assign meas_p1 = (meas_q == '1) ? meas_q : meas_q + TIME_W'(1);
    assign sn_reached = pwm_on_low_side ? switch_node_low : switch_node_high;
    assign sn_released = pwm_on_low_side ? switch_node_high : switch_node_low;
    assign ramp_up = (ramp_q >= cfg.max_drive_current) ? cfg.max_drive_current : ramp_q + CODE_W'(1);
    assign on_done = clk_en & (st_q == agds_pkg::AGDS_CHG) & sn_reached;
    assign off_done = clk_en & (st_q == agds_pkg::AGDS_DIS) & ccp_end;
    always_comb begin
        st_d = st_q;
        cnt_d = (cnt_q == '0) ? cnt_q : cnt_m1;
        act_d = act_q;
        fw_d = fw_q;
        unique case (st_q)
            agds_pkg::AGDS_IDLE_ON: begin
                if (rise) begin
                    st_d = agds_pkg::AGDS_CCP_ON;
                    cnt_d = fw_ccp;
                    act_d = '{on: 1'b0, source: 1'b0, code: cfg.discharge_current};
                    fw_d = '{on: 1'b1, source: 1'b0, code: cfg.freewheel_gate_current};
                end
            end
            agds_pkg::AGDS_CCP_ON: begin
                if (cnt_end) begin
                    st_d = agds_pkg::AGDS_PRECHG;
                    cnt_d = cfg.precharge_duration;
                    act_d = '{on: 1'b1, source: 1'b1, code: pre_code};
                end
            end
            agds_pkg::AGDS_PRECHG: begin
                if (cnt_end) begin
                    st_d = agds_pkg::AGDS_CHG;
                    act_d.code = cfg.charge_current;
                end
            end
            agds_pkg::AGDS_CHG: begin
                if (sn_reached) begin
                    st_d = agds_pkg::AGDS_POSTCHG;
                end
            end
            agds_pkg::AGDS_POSTCHG: begin
                act_d.code = ramp_up;
                if (fv_end) begin
                    act_d.code = cfg.max_drive_current;
                    st_d = agds_pkg::AGDS_SYM;
                    cnt_d = '0;
                end
            end
            agds_pkg::AGDS_SYM: begin
                if (fall) begin
                    cnt_d = fw_ccp;
                end
                if ((fall && fw_ccp == '0) || (cnt_q != '0 && cnt_end)) begin
                    st_d = agds_pkg::AGDS_PREDIS;
                    cnt_d = cfg.predischarge_duration;
                    act_d = '{on: 1'b1, source: 1'b0, code: pdis_code};
                end
            end
            agds_pkg::AGDS_PREDIS: begin
                if (cnt_end) begin
                    st_d = agds_pkg::AGDS_DIS;
                    act_d.code = cfg.discharge_current;
                end
            end
            agds_pkg::AGDS_DIS: begin
                if (ccp_end) begin
                    st_d = agds_pkg::AGDS_IDLE_ON;
                    act_d = '{on: 1'b1, source: 1'b0, code: cfg.discharge_current};
                end
            end
        endcase
        if (st_q == agds_pkg::AGDS_DIS && ccp_end) begin
            fw_d = '{on: active_freewheel_enable & sn_released, source: 1'b1,
                     code: cfg.freewheel_gate_current};
        end
        if (fwchg_q && fv_end && st_d == agds_pkg::AGDS_IDLE_ON) begin
            fw_d.on = 1'b0;
        end
        if (!active_freewheel_enable) begin
            fw_d.on = 1'b0;
        end
        if (!bridge_pwm_enable) begin
            st_d = agds_pkg::AGDS_IDLE_ON;
            act_d = '0;
            fw_d = '0;
        end
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= agds_pkg::AGDS_IDLE_ON;
            cnt_q <= '0;
            act_q <= '0;
            fw_q <= '0;
            pwm_q <= 1'b0;
            en_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            act_q <= act_d;
            fw_q <= fw_d;
            pwm_q <= pwm_input;
            en_q <= bridge_pwm_enable;
        end
    end
    // Delay measurement, protection and filter timers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            meas_q <= '0;
            ccp_q <= '0;
            fv_q <= '0;
            ton_q <= '0;
            toff_q <= '0;
            ramp_q <= '0;
            fwchg_q <= 1'b0;
        end else if (clk_en) begin
            meas_q <= (st_d != st_q && (st_d == agds_pkg::AGDS_PRECHG || st_d == agds_pkg::AGDS_PREDIS))
                      ? '0 : meas_p1;
            ccp_q <= (st_d == agds_pkg::AGDS_PREDIS && st_q == agds_pkg::AGDS_SYM) ?
                     cfg.active_crossconduction_time : (ccp_end ? ccp_q : ccp_q - TIME_W'(1));
            fv_q <= ((st_d == agds_pkg::AGDS_POSTCHG && st_q == agds_pkg::AGDS_CHG) ||
                     (st_q == agds_pkg::AGDS_DIS && ccp_end)) ?
                    cfg.overvoltage_filter_time : (fv_end ? fv_q : fv_q - TIME_W'(1));
            ramp_q <= (st_q == agds_pkg::AGDS_CHG) ? cfg.charge_current : ramp_up;
            fwchg_q <= (st_q == agds_pkg::AGDS_DIS && ccp_end) ? 1'b1 :
                       ((fv_end || st_d != agds_pkg::AGDS_IDLE_ON) ? 1'b0 : fwchg_q);
            if (on_done) begin
                ton_q <= meas_q;
            end
            if (off_done) begin
                toff_q <= meas_q;
            end
        end
    end
    agds_adapt #(.CODE_W(CODE_W)) u_pre (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .init_load(en_rise),
        .init_code(cfg.precharge_initial_current),
        .max_code(cfg.max_drive_current),
        .adapt_on(adapt_on),
        .filter_on(adaptation_filter_enable),
        .step_two(adaptation_step_size),
        .meas_done(on_done),
        .too_long(meas_q > cfg.turn_on_target),
        .too_short(meas_q < cfg.turn_on_target),
        .code(pre_code)
    );
    agds_adapt #(.CODE_W(CODE_W)) u_pdis (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .init_load(en_rise),
        .init_code(cfg.predischarge_initial_current),
        .max_code(cfg.max_drive_current),
        .adapt_on(adapt_on),
        .filter_on(adaptation_filter_enable),
        .step_two(adaptation_step_size),
        .meas_done(off_done),
        .too_long(meas_q > cfg.turn_off_target),
        .too_short(meas_q < cfg.turn_off_target),
        .code(pdis_code)
    );
    assign high_gate = pwm_on_low_side ? fw_q : act_q;
    assign low_gate = pwm_on_low_side ? act_q : fw_q;
    assign phase = st_q;
    assign precharge_current = pre_code;
    assign predischarge_current = pdis_code;
    assign turn_on_delay = ton_q;
    assign turn_off_delay = toff_q;
    // active gate held off during rising-edge protection
    chk_ccp_act_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_q == agds_pkg::AGDS_CCP_ON |-> !act_q.on)
        else $error("active gate on during protection");
    chk_prechg_code: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && bridge_pwm_enable && st_q == agds_pkg::AGDS_CCP_ON && cnt_end
        |=> act_q.code == $past(pre_code) && act_q.source)
        else $error("pre-charge code wrong");
    chk_chg_end: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && bridge_pwm_enable && st_q == agds_pkg::AGDS_CHG && sn_reached
        |=> st_q == agds_pkg::AGDS_POSTCHG)
        else $error("charge did not end");
    chk_passive_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && !active_freewheel_enable |=> !fw_q.on)
        else $error("complementary gate on in passive mode");
    chk_passive_skip: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clk_en && bridge_pwm_enable && !active_freewheel_enable && st_q == agds_pkg::AGDS_CCP_ON
        |=> st_q != agds_pkg::AGDS_CCP_ON)
        else $error("protection not skipped");
    chk_swap: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pwm_on_low_side && active_freewheel_enable && st_q == agds_pkg::AGDS_CCP_ON
        |-> high_gate.on && !high_gate.source && !low_gate.on)
        else $error("gate roles not swapped");
    chk_ton_latch: assert property (@(posedge ref_clk) disable iff (!reset_n)
        on_done |=> turn_on_delay == $past(meas_q))
        else $error("turn-on delay not latched");
    cov_full_on: cover property (@(posedge ref_clk) st_q == agds_pkg::AGDS_POSTCHG);
    cov_full_off: cover property (@(posedge ref_clk) off_done);
    cov_low_map: cover property (@(posedge ref_clk) pwm_on_low_side && on_done);
endmodule

// file: tb/agds_bridge_model.sv
// Model of the external MOSFET pair and the switch node
// Assumes one clock; node follows the high gate when charged, else the low gate when charged, else the freewheel input
`timescale 1ns/10ps
module agds_bridge_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Gate drives and load
    input wire agds_pkg::agds_gate_s high_gate,
    input wire agds_pkg::agds_gate_s low_gate,
    input wire logic freewheel_high,
    input wire logic [7:0] switch_delay,
    // Comparators
    output logic switch_node_high,
    output logic switch_node_low
);
    logic high_on_q;
    logic low_on_q;
    logic node_q;
    logic [7:0] wait_q;
    wire logic target;
    // Freewheel current sets the node when no gate is charged
    assign target = high_on_q ? 1'b1 : (low_on_q ? 1'b0 : freewheel_high);
    assign switch_node_high = node_q;
    assign switch_node_low = !node_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            high_on_q <= 1'b0;
            low_on_q <= 1'b0;
            node_q <= 1'b0;
            wait_q <= 8'h00;
        end else begin
            if (high_gate.on) high_on_q <= high_gate.source;
            if (low_gate.on) low_on_q <= low_gate.source;
            if (target == node_q) begin
                wait_q <= 8'h00;
            end else if (wait_q >= switch_delay) begin
                node_q <= target;
                wait_q <= 8'h00;
            end else begin
                wait_q <= wait_q + 8'h01;
            end
        end
    end
endmodule

// file: tb/testbench.sv
// Self-checking bench of the gate drive sequencer
// Assumes the bridge model on the gate side, config changed only in the idle phase
`timescale 1ns/10ps
module testbench;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic pwm_input = 1'b0;
    logic bridge_pwm_enable = 1'b0;
    logic pwm_on_low_side = 1'b0;
    logic active_freewheel_enable = 1'b1;
    logic [1:0] adaptive_gate_control_select = 2'b01;
    logic adaptation_filter_enable = 1'b0;
    logic adaptation_step_size = 1'b0;
    logic freewheel_high = 1'b0;
    logic [7:0] switch_delay = 8'h03;
    agds_pkg::agds_cfg_s cfg;
    wire logic switch_node_high;
    wire logic switch_node_low;
    agds_pkg::agds_gate_s high_gate;
    agds_pkg::agds_gate_s low_gate;
    agds_pkg::agds_state_e phase;
    agds_pkg::agds_code_t precharge_current;
    agds_pkg::agds_code_t predischarge_current;
    agds_pkg::agds_time_t turn_on_delay;
    agds_pkg::agds_time_t turn_off_delay;
    wire agds_pkg::agds_gate_s hs;
    wire agds_pkg::agds_gate_s ls;
    int fails = 0;
    int samples_checked = 0;
    int dur [256];
    int cnt = 0;
    int n;
    logic [7:0] last_phase = 8'h01;
    logic [5:0] prev_code = 6'h00;
    logic [5:0] exp_pre;
    logic [5:0] exp_pd;
    logic [1:0] hist_on;
    logic [1:0] hist_off;
    logic off_long = 1'b0;
    logic [7:0] t0;
    logic [4:0] tbl [7] = '{5'h09, 5'h0B, 5'h1A, 5'h15, 5'h15, 5'h0E, 5'h0E};

    always #25 ref_clk = ~ref_clk;
    assign hs = pwm_on_low_side ? low_gate : high_gate;
    assign ls = pwm_on_low_side ? high_gate : low_gate;

    agds_seq i_agds_seq (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .pwm_input(pwm_input),
        .bridge_pwm_enable(bridge_pwm_enable), .pwm_on_low_side(pwm_on_low_side),
        .active_freewheel_enable(active_freewheel_enable),
        .adaptive_gate_control_select(adaptive_gate_control_select),
        .adaptation_filter_enable(adaptation_filter_enable), .adaptation_step_size(adaptation_step_size),
        .cfg(cfg), .switch_node_high(switch_node_high), .switch_node_low(switch_node_low),
        .high_gate(high_gate), .low_gate(low_gate), .phase(phase), .precharge_current(precharge_current),
        .predischarge_current(predischarge_current), .turn_on_delay(turn_on_delay),
        .turn_off_delay(turn_off_delay));
    agds_bridge_model i_agds_bridge_model (.ref_clk(ref_clk), .reset_n(reset_n), .high_gate(high_gate),
        .low_gate(low_gate), .freewheel_high(freewheel_high), .switch_delay(switch_delay),
        .switch_node_high(switch_node_high), .switch_node_low(switch_node_low));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    function automatic logic [5:0] adj(input logic [5:0] c, input logic up, input logic dn);
        logic [7:0] v;
        logic [7:0] s;
        v = {2'b00, c};
        s = adaptation_step_size ? 8'h02 : 8'h01;
        if (up) v = v + s;
        else if (dn) v = (v < s) ? 8'h00 : v - s;
        if (v > {2'b00, cfg.max_drive_current}) v = {2'b00, cfg.max_drive_current};
        return v[5:0];
    endfunction

    task automatic wait_phase(input agds_pkg::agds_state_e s);
        int k;
        k = 0;
        while (phase !== s && k < 300) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        check(phase, s);
    endtask

    task automatic pwm_cycle(input logic [7:0] d);
        @(posedge ref_clk);
        switch_delay <= d;
        pwm_input <= 1'b1;
        wait_phase(agds_pkg::AGDS_SYM);
        repeat (2) @(posedge ref_clk);
        pwm_input <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (phase !== agds_pkg::AGDS_PREDIS && n < 100);
        wait_phase(agds_pkg::AGDS_IDLE_ON);
        repeat (3) @(posedge ref_clk);
        #1;
        if (adaptive_gate_control_select[1]) begin
            if (!adaptation_filter_enable || hist_on == {d > 8'h03, d < 8'h03})
                exp_pre = adj(exp_pre, d > 8'h03, d < 8'h03);
            if (!adaptation_filter_enable || hist_off == {off_long, !off_long})
                exp_pd = adj(exp_pd, off_long, !off_long);
        end
        hist_on = {d > 8'h03, d < 8'h03};
        hist_off = {off_long, !off_long};
        check(precharge_current, exp_pre);
        check(predischarge_current, exp_pd);
    endtask

    task automatic restart(input logic [1:0] a);
        @(posedge ref_clk);
        bridge_pwm_enable <= 1'b0;
        adaptive_gate_control_select <= a;
        @(posedge ref_clk);
        bridge_pwm_enable <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        exp_pre = adj(cfg.precharge_initial_current, 1'b0, 1'b0);
        exp_pd = adj(cfg.predischarge_initial_current, 1'b0, 1'b0);
        hist_on = 2'b00;
        hist_off = 2'b00;
        check(precharge_current, exp_pre);
        check(predischarge_current, exp_pd);
    endtask

    // Per-phase gate drive and duration watch
    always @(negedge ref_clk) begin
        if (reset_n && bridge_pwm_enable) begin
            case (phase)
                agds_pkg::AGDS_CCP_ON: if (active_freewheel_enable) begin
                    check(ls, {2'b10, cfg.freewheel_gate_current});
                    check(hs.on, 1'b0);
                end
                agds_pkg::AGDS_PRECHG: check(hs, {2'b11, precharge_current});
                agds_pkg::AGDS_CHG: check(hs, {2'b11, cfg.charge_current});
                agds_pkg::AGDS_POSTCHG: if (last_phase === 8'h10)
                    check(hs.code, (prev_code >= cfg.max_drive_current) ? cfg.max_drive_current
                        : prev_code + 6'h01);
                agds_pkg::AGDS_PREDIS: check(hs, {2'b10, predischarge_current});
                agds_pkg::AGDS_DIS: begin
                    check(hs, {2'b10, cfg.discharge_current});
                    check(ls.on & ls.source, 1'b0);
                end
                default: ;
            endcase
            if (!active_freewheel_enable) check(ls.on, 1'b0);
        end
        prev_code <= hs.code;
        if (phase === last_phase) begin
            cnt <= cnt + 1;
        end else begin
            dur[last_phase] <= cnt;
            cnt <= 1;
        end
        last_phase <= phase;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        report_and_stop();
    end

    initial begin
        // pre-charge below blank, pre-discharge below active protection
        cfg = '{6'h10, 6'h30, 6'h08, 6'h09, 6'h05, 6'h20, 8'h03, 8'h06, 8'h02, 8'h04, 8'h1E, 8'h00, 8'hFF};
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        #1;
        check(phase, agds_pkg::AGDS_IDLE_ON);
        check({high_gate, low_gate}, 16'h0000);
        restart(2'b01);
        pwm_cycle(8'h03);
        check(n, 32'd4);
        check(dur[8'h02], 32'd3);
        check(dur[8'h04], 32'd2);
        check(dur[8'h10], 32'd30);
        check(dur[8'h40], 32'd4);
        t0 = turn_on_delay;
        pwm_cycle(8'h06);
        check(turn_on_delay - t0, 8'h03);
        @(posedge ref_clk);
        cfg.turn_on_target <= t0;
        restart(2'b10);
        for (int i = 0; i < 7; i++) begin
            @(posedge ref_clk);
            adaptive_gate_control_select <= tbl[i][4:3];
            adaptation_filter_enable <= tbl[i][2];
            adaptation_step_size <= tbl[i][1];
            pwm_cycle(tbl[i][0] ? 8'h06 : 8'h00);
        end
        @(posedge ref_clk);
        cfg.precharge_initial_current <= 6'h01;
        cfg.max_drive_current <= 6'h12;
        cfg.turn_off_target <= 8'h00;
        adaptation_filter_enable <= 1'b0;
        off_long = 1'b1;
        restart(2'b11);
        pwm_cycle(8'h00);
        @(posedge ref_clk);
        active_freewheel_enable <= 1'b0;
        bridge_pwm_enable <= 1'b0;
        restart(2'b01);
        pwm_cycle(8'h03);
        check(n < 3, 1'b1);
        @(posedge ref_clk);
        active_freewheel_enable <= 1'b1;
        pwm_on_low_side <= 1'b1;
        freewheel_high <= 1'b1;
        adaptation_filter_enable <= 1'b1;
        restart(2'b11);
        pwm_cycle(8'h03);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        pwm_input <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        check(phase, agds_pkg::AGDS_IDLE_ON);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        pwm_input <= 1'b0;
        report_and_stop();
    end
endmodule
